// file: sbc_band_compare_32.sv
// Purpose: 32-bit signed band compare with three held result flags.
// Assumes: Operands and trigger come from logic on core_clk.
// Notes: Flags change only on an executed compare or a reset.
`default_nettype none

module sbc_band_compare_32 #(
  parameter int unsigned DATA_W = sbc_pkg::SBC_DATA_W
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic trigger,
  input wire logic signed [DATA_W-1:0] test_operand,
  input wire logic signed [DATA_W-1:0] lower_limit_operand,
  input wire logic signed [DATA_W-1:0] upper_limit_operand,
  output logic greater_flag,
  output logic equal_flag,
  output logic less_flag
);
  import sbc_pkg::*;

  // ----------------------------------------
  // Types and helpers
  // ----------------------------------------
  // One bit for each outcome, in the order the outputs are listed
  typedef struct packed {
    logic greater;
    logic equal;
    logic less;
  } sbc_flags_t;

  // Turns a classification into its flag set; an unused result code lights
  // nothing rather than a wrong flag
  function automatic sbc_flags_t sbc_decode_flags(input sbc_result_t res);
    sbc_flags_t flags;
    flags.greater = (res == SBC_ABOVE);
    flags.equal = (res == SBC_INSIDE);
    flags.less = (res == SBC_BELOW);
    return flags;
  endfunction : sbc_decode_flags

  // Signed less-than kept apart from the datapath so the checks do not
  // share its mistakes
  function automatic logic sbc_lt(
    input logic signed [DATA_W-1:0] lhs,
    input logic signed [DATA_W-1:0] rhs
  );
    return lhs < rhs;
  endfunction : sbc_lt

  // ----------------------------------------
  // Compare datapath
  // ----------------------------------------
  sbc_result_t result;

  // Operands go straight in; a caller that mixes signed and unsigned words
  // gets a signed answer, so the top bit of an unsigned word reads as a sign
  sbc_band_cmp #(
    .DATA_W(DATA_W)
  ) sbc_band_cmp_inst (
    .test_operand(test_operand),
    .lower_limit_operand(lower_limit_operand),
    .upper_limit_operand(upper_limit_operand),
    .result(result)
  );

  // ----------------------------------------
  // Result flags
  // ----------------------------------------
  sbc_flags_t flags_q;

  // Flags load together so a reader never sees a mixed set; with the trigger
  // off the register keeps the last outcome, which is all a reader can rely on
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_q <= '{default: SBC_FLAG_RST};
    end else if (trigger) begin
      flags_q <= sbc_decode_flags(result);
    end
  end

  // Outputs come straight from the flag flip-flops
  assign greater_flag = flags_q.greater;
  assign equal_flag = flags_q.equal;
  assign less_flag = flags_q.less;

  // ----------------------------------------
  // Check helpers
  // ----------------------------------------
  // These signals feed the assertions only and never reach an output
  logic below_now;
  logic above_now;
  sbc_flags_t expect_q;
  logic cmp_seen_q;

  // Below is tested first so an inverted band still gives a single answer
  assign below_now = sbc_lt(test_operand, lower_limit_operand);
  assign above_now = !below_now && sbc_lt(upper_limit_operand, test_operand);

  // Outcome that the last compare should have left, worked out from the operands
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      expect_q <= '{default: SBC_FLAG_RST};
    end else if (trigger) begin
      expect_q.greater <= above_now;
      expect_q.equal <= !below_now && !above_now;
      expect_q.less <= below_now;
    end
  end

  // Marks that at least one compare has run since reset
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_seen_q <= SBC_FLAG_RST;
    end else if (trigger) begin
      cmp_seen_q <= 1'h1;
    end
  end

  // ----------------------------------------
  // Compare sequences
  // ----------------------------------------
  // A compare of an operand below the band
  sequence s_cmp_below;
    trigger && below_now;
  endsequence

  // A compare of an operand inside the band, both limits included
  sequence s_cmp_inside;
    trigger && !below_now && !above_now;
  endsequence

  // A compare of an operand above the band
  sequence s_cmp_above;
    trigger && above_now;
  endsequence

  // A compare of an operand sitting exactly on the lower limit
  sequence s_cmp_at_lower;
    trigger && (test_operand == lower_limit_operand) && !above_now;
  endsequence

  // A compare of an operand sitting exactly on the upper limit
  sequence s_cmp_at_upper;
    trigger && (test_operand == upper_limit_operand) && !below_now;
  endsequence

  // Any executed compare
  sequence s_cmp_any;
    trigger;
  endsequence

  // No compare on this edge
  sequence s_cmp_idle;
    !trigger;
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Below the band only the less flag may be on
  AST_BELOW: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_cmp_below |=> less_flag && !equal_flag && !greater_flag)
    else $error("below band did not give the less flag alone");

  // Inside the band only the equal flag may be on
  AST_INSIDE: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_cmp_inside |=> equal_flag && !less_flag && !greater_flag)
    else $error("inside band did not give the equal flag alone");

  // Above the band only the greater flag may be on
  AST_ABOVE: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_cmp_above |=> greater_flag && !less_flag && !equal_flag)
    else $error("above band did not give the greater flag alone");

  // The lower limit itself counts as inside
  AST_LOW_EDGE: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_cmp_at_lower |=> equal_flag)
    else $error("operand on the lower limit was not inside");

  // The upper limit itself counts as inside
  AST_HIGH_EDGE: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_cmp_at_upper |=> equal_flag)
    else $error("operand on the upper limit was not inside");

  // Every compare leaves exactly one flag on
  AST_ONE_HOT: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_cmp_any |=> $onehot({greater_flag, equal_flag, less_flag}))
    else $error("result flags not one-hot after a compare");

  // Never two flags at once, before or after a compare
  AST_AT_MOST_ONE: assert property (@(posedge core_clk) disable iff (sys_rst)
    $onehot0({greater_flag, equal_flag, less_flag}))
    else $error("more than one result flag on");

  // Idle edges leave the flags alone
  AST_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_cmp_idle |=> $stable({greater_flag, equal_flag, less_flag}))
    else $error("flags changed without a compare");

  // A second compare right behind the first replaces its outcome
  AST_REFRESH: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_cmp_inside ##1 s_cmp_below |=> less_flag && !equal_flag && !greater_flag)
    else $error("second compare did not refresh the flags");

  // Flags after a compare match the outcome worked out from its operands
  AST_MATCH: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_cmp_any |=> ({greater_flag, equal_flag, less_flag} == expect_q))
    else $error("flags do not match the latest compare");

  // Until the first compare the flags keep their reset value
  AST_FRESH: assert property (@(posedge core_clk) disable iff (sys_rst)
    !cmp_seen_q |-> !greater_flag && !equal_flag && !less_flag)
    else $error("flag on before any compare");
endmodule : sbc_band_compare_32

`default_nettype wire

// file: sbc_pkg.sv
// Purpose: Shared constants and types for the signed band comparator.
// Assumes: One clock, one asynchronous active-high reset.
// Notes: Flag reset values and the result encoding live here.
`default_nettype none

package sbc_pkg;
  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int unsigned SBC_DATA_W = 32;
  localparam logic SBC_FLAG_RST = 1'b0;

  // Outcome of one compare
  typedef enum logic [1:0] {
    SBC_BELOW,
    SBC_INSIDE,
    SBC_ABOVE
  } sbc_result_t;
endpackage : sbc_pkg

`default_nettype wire

// file: sbc_band_cmp.sv
// Purpose: Combinational signed band classification of one operand.
// Assumes: All operands are two's-complement words of the same type.
// Notes: Pure logic, the caller registers the result.
`default_nettype none

module sbc_band_cmp #(
  parameter int unsigned DATA_W = 32
) (
  input wire logic signed [DATA_W-1:0] test_operand,
  input wire logic signed [DATA_W-1:0] lower_limit_operand,
  input wire logic signed [DATA_W-1:0] upper_limit_operand,
  output var sbc_pkg::sbc_result_t result
);
  import sbc_pkg::*;

  // ----------------------------------------
  // Classification
  // ----------------------------------------
  // Below wins over above so an inverted band still gives one answer
  always_comb begin
    if (test_operand < lower_limit_operand) begin
      result = SBC_BELOW;
    end else if (test_operand > upper_limit_operand) begin
      result = SBC_ABOVE;
    end else begin
      result = SBC_INSIDE; // Limits are inclusive
    end
  end
endmodule : sbc_band_cmp

`default_nettype wire

// file: sbc_ctrl_model.sv
// Purpose: Controlling program model that drives trigger and operands.
// Assumes: Requests arrive from the bench one cycle ahead.
// Notes: Registering requests keeps every compare on a clean edge.
`default_nettype none
module sbc_ctrl_model (
  input wire logic core_clk,
  input wire logic go,
  input wire logic signed [31:0] t_in,
  input wire logic signed [31:0] l_in,
  input wire logic signed [31:0] u_in,
  output logic trigger,
  output logic signed [31:0] test_operand,
  output logic signed [31:0] lower_limit_operand,
  output logic signed [31:0] upper_limit_operand
);
  timeunit 1ns;
  timeprecision 1ns;
  // All operands share one signed word type and stay in range
  always_ff @(posedge core_clk) begin
    trigger <= go;
    test_operand <= t_in;
    lower_limit_operand <= l_in;
    upper_limit_operand <= u_in;
  end
endmodule : sbc_ctrl_model
`default_nettype wire

// file: sbc_band_compare_32_tb.sv
// Purpose: Self-checking bench for the signed band comparator.
// Assumes: The model adds one cycle, so a compare lands two edges later.
// Notes: Flags are read just after the compare edge, in greater/equal/less order.
`default_nettype none
module sbc_band_compare_32_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic go = 1'h0;
  logic trigger;
  logic greater_flag;
  logic equal_flag;
  logic less_flag;
  logic signed [31:0] t_in = 32'sh0;
  logic signed [31:0] l_in = 32'sh0;
  logic signed [31:0] u_in = 32'sh0;
  logic signed [31:0] test_operand;
  logic signed [31:0] lower_limit_operand;
  logic signed [31:0] upper_limit_operand;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  sbc_ctrl_model sbc_ctrl_model_inst (
    .core_clk(core_clk),
    .go(go),
    .t_in(t_in),
    .l_in(l_in),
    .u_in(u_in),
    .trigger(trigger),
    .test_operand(test_operand),
    .lower_limit_operand(lower_limit_operand),
    .upper_limit_operand(upper_limit_operand)
  );
  sbc_band_compare_32 sbc_band_compare_32_inst (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .trigger(trigger),
    .test_operand(test_operand),
    .lower_limit_operand(lower_limit_operand),
    .upper_limit_operand(upper_limit_operand),
    .greater_flag(greater_flag),
    .equal_flag(equal_flag),
    .less_flag(less_flag)
  );
  initial forever #10 core_clk = ~core_clk;
  // Cut a hang short well past the expected run length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      finish_test();
    end
  end
  task automatic check(input logic [2:0] exp);
    comparisons++;
    if ({greater_flag, equal_flag, less_flag} !== exp) begin
      failures++;
      $display("[ERR] %0t flags %b want %b", $time, {greater_flag, equal_flag, less_flag}, exp);
    end
  endtask : check
  task automatic compare(input logic signed [31:0] t, l, u, input logic [2:0] exp);
    @(posedge core_clk);
    go <= 1;
    t_in <= t;
    l_in <= l;
    u_in <= u;
    @(posedge core_clk);
    go <= 0;
    @(posedge core_clk);
    #1 check(exp);
  endtask : compare
  // Edges of the band, both signs and the extreme words
  task automatic run_bands();
    compare(32'sh23, 32'sh0, 32'sh64, 3'b010);
    compare(32'sh0, 32'sh0, 32'sh64, 3'b010);
    compare(32'sh64, 32'sh0, 32'sh64, 3'b010);
    compare(-32'sh1, 32'sh0, 32'sh64, 3'b001);
    compare(32'sh65, 32'sh0, 32'sh64, 3'b100);
    compare(32'sh80000000, -32'sh5, 32'sh5, 3'b001);
    compare(32'sh7fffffff, -32'sh5, 32'sh5, 3'b100);
    compare(32'sh5, 32'sh64, 32'sh0, 3'b001);
    compare(32'sh65, 32'sh64, 32'sh0, 3'b100);
  endtask : run_bands
  // Two compares on consecutive edges, the first outcome stands one cycle
  task automatic run_burst();
    @(posedge core_clk);
    go <= 1;
    t_in <= 32'sh0;
    l_in <= 32'sh0;
    u_in <= 32'sh64;
    @(posedge core_clk);
    t_in <= -32'sh1;
    @(posedge core_clk);
    go <= 0;
    #1 check(3'b010);
    @(posedge core_clk);
    #1 check(3'b001);
  endtask : run_burst
  // Operands move while idle, flags must not
  task automatic run_hold();
    compare(32'sh23, 32'sh0, 32'sh64, 3'b010);
    @(posedge core_clk);
    t_in <= 32'sh7fffffff;
    l_in <= -32'sh5;
    u_in <= 32'sh5;
    repeat (3) @(posedge core_clk);
    #1 check(3'b010);
  endtask : run_hold
  // Small BCD-coded words compare as plain positive numbers
  task automatic run_bcd();
    compare(32'sh00000123, 32'sh00000100, 32'sh00000999, 3'b010);
    compare(32'sh00000099, 32'sh00000100, 32'sh00000999, 3'b001);
  endtask : run_bcd
  // Reset in mid-run clears the flags, a compare on the first edge after counts
  task automatic run_reset();
    compare(32'sh65, 32'sh0, 32'sh64, 3'b100);
    @(posedge core_clk);
    sys_rst <= 1;
    #1 check(3'b000);
    @(posedge core_clk);
    go <= 1;
    t_in <= -32'sh1;
    @(posedge core_clk);
    sys_rst <= 0;
    go <= 0;
    @(posedge core_clk);
    #1 check(3'b001);
  endtask : run_reset
  task automatic finish_test();
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 0;
    @(posedge core_clk);
    #1 check(3'b000);
    run_bands();
    run_burst();
    run_hold();
    run_bcd();
    run_reset();
    finish_test();
  end
endmodule : sbc_band_compare_32_tb
`default_nettype wire
